// File: verilog/bstap_core.sv
// Boundary-scan test access port: controller, instruction and data registers
`timescale 1ns/1ps
module bstap_core #(
   parameter int CELLS = 48
) (
   // System clock and reset
   input  wire logic             MCLK,
   input  wire logic             RESET,
   // Test access port pins
   input  wire logic             TCK,
   input  wire logic             TMS,
   input  wire logic             TDI,
   output logic                  TDO_O,
   output logic                  TDO_OE_N,
   // Boundary pins and test controls
   input  wire logic [CELLS-1:0] CELL_IN,
   output logic      [CELLS-1:0] CELL_OUT,
   output logic                  TEST_MODE,
   output logic                  OUT_HIGHZ
);
   // Pin synchronisers; TCK edges are found on the second stage
   logic [2:0]       tck_q;
   logic [1:0]       tms_q;
   logic [1:0]       tdi_q;
   logic [CELLS-1:0] pin1_q;
   logic [CELLS-1:0] pin2_q;
   logic             rise;
   logic             fall;
   logic             tms_s;
   logic             tdi_s;

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         tck_q  <= 3'h0;
         tms_q  <= 2'h3;
         tdi_q  <= 2'h3;
         pin1_q <= '0;
         pin2_q <= '0;
      end
      else
      begin
         tck_q  <= {tck_q[1:0], TCK};
         tms_q  <= {tms_q[0], TMS};
         tdi_q  <= {tdi_q[0], TDI};
         pin1_q <= CELL_IN;
         pin2_q <= pin1_q;
      end
   end

   assign rise  = tck_q[1] & ~tck_q[2];
   assign fall  = ~tck_q[1] & tck_q[2];
   assign tms_s = tms_q[1];
   assign tdi_s = tdi_q[1];

   // Instruction decode with parity check, used for the holding latch
   function automatic bstap_pkg::bstap_instr_e decode(input logic [7:0] op);
      bstap_pkg::bstap_instr_e r;
      r = bstap_pkg::I_BYPASS;
      if (^op == 1'b0)
      begin
         case (op[6:0])
            bstap_pkg::OP_EXTEST:    r = bstap_pkg::I_EXTEST;
            bstap_pkg::OP_IDCODE:    r = bstap_pkg::I_IDCODE;
            bstap_pkg::OP_SAMPLE:    r = bstap_pkg::I_SAMPLE;
            bstap_pkg::OP_HIGHZ:     r = bstap_pkg::I_HIGHZ;
            bstap_pkg::OP_CLAMP:     r = bstap_pkg::I_CLAMP;
            bstap_pkg::OP_RUN_TEST:  r = bstap_pkg::I_RUN_TEST;
            bstap_pkg::OP_READ_NORM: r = bstap_pkg::I_READ_NORM;
            bstap_pkg::OP_READ_TEST: r = bstap_pkg::I_READ_TEST;
            bstap_pkg::OP_SELF_TEST: r = bstap_pkg::I_SELF_TEST;
            bstap_pkg::OP_TSEL_SCAN: r = bstap_pkg::I_TSEL_SCAN;
            default:                 r = bstap_pkg::I_BYPASS;
         endcase
      end
      return r;
   endfunction : decode

   // Controller state machine
   bstap_pkg::bstap_state_e st_q;
   bstap_pkg::bstap_state_e st_d;

   always_comb
   begin
      case (st_q)
         bstap_pkg::ST_RESET:     st_d = tms_s ? bstap_pkg::ST_RESET : bstap_pkg::ST_IDLE;
         bstap_pkg::ST_IDLE:      st_d = tms_s ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
         bstap_pkg::ST_SEL_DR:    st_d = tms_s ? bstap_pkg::ST_SEL_INS : bstap_pkg::ST_CAP_DR;
         bstap_pkg::ST_CAP_DR:    st_d = tms_s ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
         bstap_pkg::ST_SHIFT_DR:  st_d = tms_s ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
         bstap_pkg::ST_EXIT1_DR:  st_d = tms_s ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_PAUSE_DR;
         bstap_pkg::ST_PAUSE_DR:  st_d = tms_s ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
         bstap_pkg::ST_EXIT2_DR:  st_d = tms_s ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_SHIFT_DR;
         bstap_pkg::ST_UPD_DR:    st_d = tms_s ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
         bstap_pkg::ST_SEL_INS:   st_d = tms_s ? bstap_pkg::ST_RESET : bstap_pkg::ST_CAP_INS;
         bstap_pkg::ST_CAP_INS:   st_d = tms_s ? bstap_pkg::ST_EXIT1_INS : bstap_pkg::ST_SHIFT_INS;
         bstap_pkg::ST_SHIFT_INS: st_d = tms_s ? bstap_pkg::ST_EXIT1_INS : bstap_pkg::ST_SHIFT_INS;
         bstap_pkg::ST_EXIT1_INS: st_d = tms_s ? bstap_pkg::ST_UPD_INS : bstap_pkg::ST_PAUSE_INS;
         bstap_pkg::ST_PAUSE_INS: st_d = tms_s ? bstap_pkg::ST_EXIT2_INS : bstap_pkg::ST_PAUSE_INS;
         bstap_pkg::ST_EXIT2_INS: st_d = tms_s ? bstap_pkg::ST_UPD_INS : bstap_pkg::ST_SHIFT_INS;
         bstap_pkg::ST_UPD_INS:   st_d = tms_s ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
         default:                 st_d = bstap_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         st_q <= bstap_pkg::ST_RESET;
      else if (rise)
         st_q <= st_d;
   end

   // Instruction register: shift stage and holding latch
   logic [7:0]              instr_shift_q;
   logic [7:0]              instr_hold_q;
   bstap_pkg::bstap_instr_e cur;

   assign cur = decode(instr_hold_q);

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         instr_shift_q <= bstap_pkg::INSTR_RESET;
      else if (rise && st_q == bstap_pkg::ST_CAP_INS)
         instr_shift_q <= bstap_pkg::INSTR_CAPTURE;
      else if (rise && st_q == bstap_pkg::ST_SHIFT_INS)
         instr_shift_q <= {tdi_s, instr_shift_q[7:1]};
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         instr_hold_q <= bstap_pkg::INSTR_RESET;
      else if (st_q == bstap_pkg::ST_RESET)
         instr_hold_q <= bstap_pkg::INSTR_RESET;
      else if (fall && st_q == bstap_pkg::ST_UPD_INS)
         instr_hold_q <= instr_shift_q;
   end

   // Data register selection and capture
   logic sel_cells;
   logic sel_ident;
   logic sel_tsel;

   assign sel_cells = cur inside {bstap_pkg::I_EXTEST, bstap_pkg::I_SAMPLE, bstap_pkg::I_READ_NORM,
                                  bstap_pkg::I_READ_TEST, bstap_pkg::I_SELF_TEST};
   assign sel_ident = cur == bstap_pkg::I_IDCODE;
   assign sel_tsel  = cur == bstap_pkg::I_TSEL_SCAN;

   logic [CELLS-1:0] cell_shift_q;
   logic [CELLS-1:0] cell_hold_q;
   logic [2:0]       tsel_shift_q;
   logic [2:0]       tsel_hold_q;
   logic [31:0]      ident_q;
   logic             byp_q;
   logic             run_sig;

   assign run_sig = tsel_hold_q == bstap_pkg::TSEL_SIG;

   // Boundary chain shift stage; contents survive pause and exit states
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         cell_shift_q <= '0;
      else if (rise && sel_cells && st_q == bstap_pkg::ST_CAP_DR)
      begin
         if (cur inside {bstap_pkg::I_EXTEST, bstap_pkg::I_SAMPLE})
            cell_shift_q <= pin2_q;
         else
            cell_shift_q <= cell_hold_q;
      end
      else if (rise && sel_cells && st_q == bstap_pkg::ST_SHIFT_DR)
         cell_shift_q <= {tdi_s, cell_shift_q[CELLS-1:1]};
      else if (rise && st_q == bstap_pkg::ST_IDLE && cur == bstap_pkg::I_RUN_TEST)
      begin
         // Signature compression of pins, otherwise a binary count
         if (run_sig)
            cell_shift_q <= {cell_shift_q[CELLS-2:0], cell_shift_q[CELLS-1] ^ cell_shift_q[0]} ^ pin2_q;
         else
            cell_shift_q <= cell_shift_q + 1'b1;
      end
   end

   // Boundary chain holding latches; reset loads every cell, Test-Logic-Reset only the enable cells
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         cell_hold_q <= '0;
         cell_hold_q[CELLS-1:bstap_pkg::CELL_OE_LSB] <= bstap_pkg::CELL_OE_RESET;
      end
      else if (st_q == bstap_pkg::ST_RESET)
         cell_hold_q[CELLS-1:bstap_pkg::CELL_OE_LSB] <= bstap_pkg::CELL_OE_RESET;
      else if (fall && sel_cells && st_q == bstap_pkg::ST_UPD_DR
               && cur inside {bstap_pkg::I_EXTEST, bstap_pkg::I_SAMPLE, bstap_pkg::I_SELF_TEST})
         cell_hold_q <= cell_shift_q;
   end

   // Test select register; capture leaves it unchanged
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         tsel_shift_q <= bstap_pkg::TSEL_RESET;
      else if (st_q == bstap_pkg::ST_RESET)
         tsel_shift_q <= bstap_pkg::TSEL_RESET;
      else if (rise && sel_tsel && st_q == bstap_pkg::ST_SHIFT_DR)
         tsel_shift_q <= {tdi_s, tsel_shift_q[2:1]};
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         tsel_hold_q <= bstap_pkg::TSEL_RESET;
      else if (st_q == bstap_pkg::ST_RESET)
         tsel_hold_q <= bstap_pkg::TSEL_RESET;
      else if (fall && sel_tsel && st_q == bstap_pkg::ST_UPD_DR)
         tsel_hold_q <= tsel_shift_q;
   end

   // Identification and bypass: shift stage only, no latch
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         ident_q <= bstap_pkg::IDENT_VALUE;
      else if (rise && sel_ident && st_q == bstap_pkg::ST_CAP_DR)
         ident_q <= bstap_pkg::IDENT_VALUE;
      else if (rise && sel_ident && st_q == bstap_pkg::ST_SHIFT_DR)
         ident_q <= {tdi_s, ident_q[31:1]};
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         byp_q <= 1'b0;
      else if (rise && st_q == bstap_pkg::ST_CAP_DR)
         byp_q <= 1'b0;
      else if (rise && st_q == bstap_pkg::ST_SHIFT_DR)
         byp_q <= tdi_s;
   end

   // Serial output; changes only on falling TCK so the controller samples a settled bit
   logic dr_lsb;

   always_comb
   begin
      if (sel_cells)
         dr_lsb = cell_shift_q[0];
      else if (sel_ident)
         dr_lsb = ident_q[0];
      else if (sel_tsel)
         dr_lsb = tsel_shift_q[0];
      else
         dr_lsb = byp_q;
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         TDO_O    <= 1'b0;
         TDO_OE_N <= 1'b1;
      end
      else if (fall)
      begin
         if (st_q == bstap_pkg::ST_SHIFT_DR)
         begin
            TDO_O    <= dr_lsb;
            TDO_OE_N <= 1'b0;
         end
         else if (st_q == bstap_pkg::ST_SHIFT_INS)
         begin
            TDO_O    <= instr_shift_q[0];
            TDO_OE_N <= 1'b0;
         end
         else
            TDO_OE_N <= 1'b1;
      end
   end

   // Mode outputs follow the holding latches
   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
      begin
         TEST_MODE <= 1'b0;
         OUT_HIGHZ <= 1'b0;
      end
      else
      begin
         TEST_MODE <= cur inside {bstap_pkg::I_EXTEST, bstap_pkg::I_HIGHZ, bstap_pkg::I_CLAMP,
                                  bstap_pkg::I_RUN_TEST, bstap_pkg::I_READ_TEST};
         OUT_HIGHZ <= cur == bstap_pkg::I_HIGHZ;
      end
   end

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         CELL_OUT <= '0;
      else
         CELL_OUT <= cell_hold_q;
   end

   // Helper: consecutive rising edges with TMS high
   logic [2:0] tms_hi_q;

   always_ff @(posedge MCLK or posedge RESET)
   begin
      if (RESET)
         tms_hi_q <= 3'h0;
      else if (rise)
         tms_hi_q <= !tms_s ? 3'h0 : (tms_hi_q == bstap_pkg::TMS_RESET_EDGES) ? tms_hi_q : tms_hi_q + 3'h1;
   end

   tms_reset_a: assert property (@(posedge MCLK) disable iff (RESET)
      tms_hi_q == bstap_pkg::TMS_RESET_EDGES |-> st_q == bstap_pkg::ST_RESET)
      else $error("TMS held high did not reach reset state");

   capture_ins_a: assert property (@(posedge MCLK) disable iff (RESET)
      rise && st_q == bstap_pkg::ST_CAP_INS |=> instr_shift_q == bstap_pkg::INSTR_CAPTURE)
      else $error("Instruction capture pattern wrong");

   shift_ins_a: assert property (@(posedge MCLK) disable iff (RESET)
      rise && st_q == bstap_pkg::ST_SHIFT_INS |=> instr_shift_q == {$past(tdi_s), $past(instr_shift_q[7:1])})
      else $error("Instruction shift wrong");

   tdo_release_a: assert property (@(posedge MCLK) disable iff (RESET)
      fall && st_q inside {bstap_pkg::ST_EXIT1_DR, bstap_pkg::ST_EXIT1_INS} |=> TDO_OE_N)
      else $error("TDO not released after exit");

   tdo_drive_a: assert property (@(posedge MCLK) disable iff (RESET)
      fall && st_q == bstap_pkg::ST_SHIFT_DR |=> !TDO_OE_N && TDO_O == $past(dr_lsb))
      else $error("TDO not driving data LSB");

   ins_update_a: assert property (@(posedge MCLK) disable iff (RESET)
      fall && st_q == bstap_pkg::ST_UPD_INS |=> instr_hold_q == $past(instr_shift_q))
      else $error("Instruction not updated");

   bypass_cap_a: assert property (@(posedge MCLK) disable iff (RESET)
      rise && st_q == bstap_pkg::ST_CAP_DR |=> !byp_q)
      else $error("Bypass did not capture zero");

   tsel_keep_a: assert property (@(posedge MCLK) disable iff (RESET)
      rise && st_q == bstap_pkg::ST_CAP_DR |=> $stable(tsel_shift_q) && $stable(tsel_hold_q))
      else $error("Test select changed in capture");

   pause_keep_a: assert property (@(posedge MCLK) disable iff (RESET)
      st_q == bstap_pkg::ST_PAUSE_DR |=> $stable(cell_shift_q) && $stable(ident_q))
      else $error("Data lost in pause");

   reset_ins_a: assert property (@(posedge MCLK) disable iff (RESET)
      st_q == bstap_pkg::ST_RESET |=> instr_hold_q == bstap_pkg::INSTR_RESET
                                      && tsel_hold_q == bstap_pkg::TSEL_RESET)
      else $error("Reset values not forced");
endmodule : bstap_core

// File: verilog/bstap_pkg.sv
// Constants, opcodes and state codes for the boundary-scan test access logic
package bstap_pkg;
   // Instruction register values
   localparam logic [7:0] INSTR_RESET   = 8'h81;
   localparam logic [7:0] INSTR_CAPTURE = 8'h81;
   // Boundary cell chain: output-enable cells reset high
   localparam int         CELL_OE_LSB   = 44;
   localparam logic [3:0] CELL_OE_RESET = 4'hF;
   // Boundary test select register
   localparam logic [2:0] TSEL_RESET    = 3'h2;
   localparam logic [2:0] TSEL_SIG      = 3'h2;
   // Consecutive TMS-high rising edges that force Test-Logic-Reset
   localparam logic [2:0] TMS_RESET_EDGES = 3'h5;
   // Identification word, value arbitrary
   localparam logic [31:0] IDENT_VALUE  = 32'h0000_0001;
   // Opcodes, bits 6..0 (bit 7 is even parity over the whole byte)
   localparam logic [6:0] OP_EXTEST     = 7'h00;
   localparam logic [6:0] OP_IDCODE     = 7'h01;
   localparam logic [6:0] OP_SAMPLE     = 7'h02;
   localparam logic [6:0] OP_HIGHZ      = 7'h06;
   localparam logic [6:0] OP_CLAMP      = 7'h07;
   localparam logic [6:0] OP_RUN_TEST   = 7'h09;
   localparam logic [6:0] OP_READ_NORM  = 7'h0A;
   localparam logic [6:0] OP_READ_TEST  = 7'h0B;
   localparam logic [6:0] OP_SELF_TEST  = 7'h0C;
   localparam logic [6:0] OP_TSEL_SCAN  = 7'h0E;

   typedef enum logic [3:0] {
      I_BYPASS    = 4'b0000,
      I_EXTEST    = 4'b0001,
      I_IDCODE    = 4'b0010,
      I_SAMPLE    = 4'b0011,
      I_HIGHZ     = 4'b0100,
      I_CLAMP     = 4'b0101,
      I_RUN_TEST  = 4'b0110,
      I_READ_NORM = 4'b0111,
      I_READ_TEST = 4'b1000,
      I_SELF_TEST = 4'b1001,
      I_TSEL_SCAN = 4'b1010
   } bstap_instr_e;

   typedef enum logic [3:0] {
      ST_RESET     = 4'b0000,
      ST_IDLE      = 4'b0001,
      ST_SEL_DR    = 4'b0010,
      ST_CAP_DR    = 4'b0011,
      ST_SHIFT_DR  = 4'b0100,
      ST_EXIT1_DR  = 4'b0101,
      ST_PAUSE_DR  = 4'b0110,
      ST_EXIT2_DR  = 4'b0111,
      ST_UPD_DR    = 4'b1000,
      ST_SEL_INS   = 4'b1001,
      ST_CAP_INS   = 4'b1010,
      ST_SHIFT_INS = 4'b1011,
      ST_EXIT1_INS = 4'b1100,
      ST_PAUSE_INS = 4'b1101,
      ST_EXIT2_INS = 4'b1110,
      ST_UPD_INS   = 4'b1111
   } bstap_state_e;
endpackage : bstap_pkg

// File: verification/bstap_jtag_ctrl.sv
// External test controller model that drives the four-wire test port
`timescale 1ns/1ps
module bstap_jtag_ctrl (
   // Reference clock used to time the test clock
   input  wire logic mclk,
   // Test port
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo_o,
   input  wire logic tdo_oe_n
);
   logic tdo_seen;
   logic oe_seen;

   initial
   begin
      tck      = 1'b0;
      tms      = 1'b1;
      tdi      = 1'b1;
      tdo_seen = 1'b0;
      oe_seen  = 1'b1;
   end

   // One 80 ns test clock; the clock stands low between calls
   task automatic pulse(input logic m, input logic d);
      tms = m;
      tdi = d;
      repeat (8) @(negedge mclk);
      tck      = 1'b1;
      // No pull on the data pin, so a released pin reads as the opposite level
      tdo_seen = tdo_oe_n ? ~tdo_o : tdo_o;
      oe_seen  = tdo_oe_n;
      repeat (8) @(negedge mclk);
      tck = 1'b0;
   endtask : pulse

   // Five high TMS clocks from any state, then on to Run-Test/Idle
   task automatic tlr();
      repeat (5) pulse(1'b1, ~tdi);
      pulse(1'b0, ~tdi);
   endtask : tlr

   // Scan from Idle back to Idle, LSB first, with an optional pause
   task automatic scan(input logic to_instr, input int n, input logic [63:0] din, input int pause_at,
                       output logic [63:0] dout, output logic oe_ok);
      dout  = '0;
      oe_ok = 1'b1;
      pulse(1'b1, ~tdi);
      if (to_instr)
         pulse(1'b1, ~tdi);
      pulse(1'b0, ~tdi);
      pulse(1'b0, ~tdi);
      // Pin must still be released on the rise that enters the shift state
      oe_ok &= oe_seen;
      for (int i = 0; i < n; i++)
      begin
         pulse((i == n - 1) || (i == pause_at - 1), din[i]);
         dout[i] = tdo_seen;
         oe_ok  &= ~oe_seen;
         if (i == pause_at - 1 && i != n - 1)
         begin
            pulse(1'b0, ~tdi);
            oe_ok &= oe_seen;
            repeat (3) pulse(1'b0, ~tdi);
            pulse(1'b1, ~tdi);
            pulse(1'b0, ~tdi);
            oe_ok &= oe_seen;
         end
      end
      pulse(1'b1, ~tdi);
      oe_ok &= oe_seen;
      pulse(1'b0, ~tdi);
   endtask : scan
endmodule : bstap_jtag_ctrl

// File: verification/bstap_core_tb.sv
// Self-checking testbench for the boundary-scan test access logic
`timescale 1ns/1ps
`define CHK(name, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         miscompares++; \
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
      end \
   end
module bstap_core_tb;
   logic        mclk;
   logic        reset;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        tdo_o;
   logic        tdo_oe_n;
   logic [47:0] cell_in;
   logic [47:0] cell_out;
   logic        test_mode;
   logic        out_highz;
   logic [63:0] dout;
   logic [63:0] pat;
   logic        oe_ok;
   int          total_checks;
   int          miscompares;
   logic [7:0]  ops [16] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h84, 8'h05, 8'h06, 8'h87,
                            8'h88, 8'h09, 8'h0A, 8'h8B, 8'h0C, 8'h8E, 8'h01, 8'hFF};

   bstap_core bstap_core_inst (
      .MCLK     (mclk),
      .RESET    (reset),
      .TCK      (tck),
      .TMS      (tms),
      .TDI      (tdi),
      .TDO_O    (tdo_o),
      .TDO_OE_N (tdo_oe_n),
      .CELL_IN  (cell_in),
      .CELL_OUT (cell_out),
      .TEST_MODE(test_mode),
      .OUT_HIGHZ(out_highz)
   );

   bstap_jtag_ctrl bstap_jtag_ctrl_inst (
      .mclk    (mclk),
      .tck     (tck),
      .tms     (tms),
      .tdi     (tdi),
      .tdo_o   (tdo_o),
      .tdo_oe_n(tdo_oe_n)
   );

   always #2.5 mclk = ~mclk;

   // Instructions that put the part in test mode
   function automatic logic exp_mode(input logic [7:0] op);
      return op inside {8'h00, 8'h06, 8'h87, 8'h09, 8'h8B};
   endfunction : exp_mode

   // Any byte not in the implemented set, bad parity included, falls back to the single stage, as do high-z, clamp and run-test
   function automatic logic exp_bypass(input logic [7:0] op);
      return !(op inside {8'h00, 8'h81, 8'h82, 8'h0A, 8'h8B, 8'h0C, 8'h8E});
   endfunction : exp_bypass

   task automatic instr_scan(input logic [7:0] op, input int p);
      bstap_jtag_ctrl_inst.scan(1'b1, 8, {56'h0, op}, p, dout, oe_ok);
      `CHK("instr capture", 8'h81, dout[7:0])
      `CHK("instr pin enable", 1'b1, oe_ok)
   endtask : instr_scan

   task automatic data_scan(input int n, input logic [63:0] din, input int p);
      bstap_jtag_ctrl_inst.scan(1'b0, n, din, p, dout, oe_ok);
      `CHK("data pin enable", 1'b1, oe_ok)
   endtask : data_scan

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : final_report

   // Watchdog sized well beyond the expected run of about 110 us
   initial
   begin
      #400_000;
      miscompares++;
      final_report();
   end

   initial
   begin
      mclk         = 1'b0;
      reset        = 1'b1;
      cell_in      = '0;
      total_checks = 0;
      miscompares  = 0;
      pat          = 64'($urandom(82862));
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      repeat (4) @(negedge mclk);
      `CHK("enable cells", 4'hF, cell_out[47:44])
      `CHK("test mode", 1'b0, test_mode)
      bstap_jtag_ctrl_inst.tlr();
      data_scan(32, pat, 0);
      `CHK("ident", bstap_pkg::IDENT_VALUE, dout[31:0])
      $display("test reset_values done");

      // Test select register: reset value, update, unchanged by capture
      instr_scan(8'h8E, 0);
      data_scan(3, 64'h5, 0);
      `CHK("select reset", 3'h2, dout[2:0])
      data_scan(3, 64'h3, 0);
      `CHK("select hold", 3'h5, dout[2:0])
      bstap_jtag_ctrl_inst.tlr();
      data_scan(32, pat, 0);
      `CHK("ident after tlr", bstap_pkg::IDENT_VALUE, dout[31:0])
      instr_scan(8'h8E, 0);
      data_scan(3, 64'h0, 0);
      `CHK("select after tlr", 3'h2, dout[2:0])
      $display("test select_register done");

      // Boundary chain: pin capture, pauses, update and latch readback
      for (int k = 0; k < 3; k++)
      begin
         pat     = {$urandom, $urandom};
         cell_in = pat[63:16];
         pat     = {$urandom, $urandom};
         instr_scan(8'h82, k * 3);
         data_scan(48, pat, k * 23);
         `CHK("pin capture", cell_in, dout[47:0])
         `CHK("latch update", pat[47:0], cell_out)
         instr_scan(8'h0A, 0);
         data_scan(48, ~pat, 0);
         `CHK("latch readback", pat[47:0], dout[47:0])
         `CHK("latch kept", pat[47:0], cell_out)
      end
      // Self test captures the latches and updates them from the shift stage
      instr_scan(8'h0C, 0);
      data_scan(48, ~pat, 0);
      `CHK("self test capture", pat[47:0], dout[47:0])
      `CHK("self test update", ~pat[47:0], cell_out)
      $display("test boundary_chain done");

      // Every listed opcode, then random bytes
      for (int k = 0; k < 24; k++)
      begin
         logic [7:0] op;
         op = (k < 16) ? ops[k] : 8'($urandom);
         instr_scan(op, 0);
         `CHK("mode", exp_mode(op), test_mode)
         `CHK("highz", op == 8'h06, out_highz)
         if (exp_bypass(op))
         begin
            pat = {$urandom, $urandom};
            data_scan(16, pat, 0);
            `CHK("bypass", {pat[14:0], 1'b0}, dout[15:0])
         end
      end
      $display("test opcodes done");

      // Second reset in mid-run while high impedance is active
      instr_scan(8'h06, 0);
      `CHK("highz set", 1'b1, out_highz)
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      repeat (4) @(negedge mclk);
      `CHK("highz cleared", 1'b0, out_highz)
      `CHK("enable cells again", 4'hF, cell_out[47:44])
      bstap_jtag_ctrl_inst.tlr();
      data_scan(32, pat, 0);
      `CHK("ident after reset", bstap_pkg::IDENT_VALUE, dout[31:0])
      $display("test second_reset done");
      final_report();
   end
endmodule : bstap_core_tb
